/* smc_pkg.sv */
package smc_pkg;
  // timing base: 125 MHz clock, 1 ms tick
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned TICK_MS         = 1;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  // muting time limit, in seconds
  localparam int unsigned MUTE_MAX_MIN_S  = 1;
  localparam int unsigned MUTE_MAX_MAX_S  = 253;
  localparam int unsigned MUTE_HOUR_S     = 3600;
  localparam int unsigned MUTE_DEF_S      = 30;
  // termination delay, in seconds
  localparam int unsigned DELAY_DEF_S     = 0;
  localparam int unsigned DELAY_MAX_S     = 30;
  localparam int unsigned DELAY_MAX_CMB_S = 195;
  // override clear window
  localparam int unsigned OVR_WIN_S       = 35;
  localparam int unsigned MS_PER_S        = 1000;
  // lamp flash half period
  localparam int unsigned FLASH_HALF_MS   = 250;
  // reset values of the time settings
  localparam logic [7:0]  MUTE_SEL_RST    = 8'h1E;
  localparam logic [7:0]  DELAY_SEL_RST   = 8'h00;
  // selector code 8'hFE picks one hour
  localparam logic [7:0]  MUTE_SEL_HOUR   = 8'hFE;

  typedef enum logic [1:0] {
    SMC_END_NORMAL,
    SMC_END_DELAYED,
    SMC_END_IMMEDIATE,
    SMC_END_COMBINED
  } smc_end_e;
endpackage : smc_pkg

/* smc_muting_controller.sv */
// How it works
// - mute only on three adjacent sensor pairs
// - muting ends at maximum muting time
// - immediate end disables muting time limit
// - time-stop pauses monitor until sensor change
// - re-mute needs all sensors released together
// - field break after mute kills outputs
// - lamp steady; flashes if one lamp bad
// - no working lamp means no muting
// - after expiry/reset start button overrides
// - override drops if field uncleared 35 s
// - no override in cycle-control mode
// - muting handed between neighbouring sensor pairs
// - delayed end holds muting for set delay
// - delayed mode: back pair, then or with field break
// - immediate end when field clears
// - combined mode ends on field clear early
// - restart interlock needs press and release
`timescale 1ns/10ps
`default_nettype none

module smc_muting_controller #(
  parameter int unsigned TICK_CYCLES = smc_pkg::TICK_CYCLES,
  parameter int unsigned OVR_WIN_MS  = smc_pkg::OVR_WIN_S * smc_pkg::MS_PER_S,
  parameter int unsigned HOUR_MS     = smc_pkg::MUTE_HOUR_S * smc_pkg::MS_PER_S,
  parameter bit          FIXED_LIMIT = 1'b0
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             sensor_front_one,
  input  wire logic             sensor_front_two,
  input  wire logic             sensor_back_one,
  input  wire logic             sensor_back_two,
  input  wire logic             field_clear,
  input  wire logic             time_stop_input,
  input  wire logic             start_button,
  input  wire logic             lamp_int_ok,
  input  wire logic             lamp_ext_ok,
  input  wire logic             restart_interlock,
  input  wire logic             cycle_mode,
  input  wire smc_pkg::smc_end_e end_mode,
  input  wire logic [7:0]       mute_limit_sel,
  input  wire logic [7:0]       end_delay_sel,
  output logic                  outputs_on,
  output logic                  muted,
  output logic                  override_active,
  output logic                  lamp_int_on,
  output logic                  lamp_ext_on
);

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  localparam int NIN = 9;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  assign raw = {sensor_front_one, sensor_front_two, sensor_back_one, sensor_back_two,
                field_clear, time_stop_input, start_button, lamp_int_ok, lamp_ext_ok};

  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  logic       f1, f2, b1, b2, clr, tstop, btn, lint, lext;
  assign {f1, f2, b1, b2, clr, tstop, btn, lint, lext} = s2_q;
  logic [3:0] sens;
  assign sens = {f1, f2, b1, b2};

  logic [3:0] sens_q;
  logic       clr_q;
  logic       btn_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      sens_q <= 4'h0;
      clr_q  <= 1'b0;
      btn_q  <= 1'b0;
    end else begin
      sens_q <= sens;
      clr_q  <= clr;
      btn_q  <= btn;
    end
  end
  logic sens_chg;
  logic btn_rel;
  assign sens_chg = (sens != sens_q);
  assign btn_rel  = btn_q & ~btn;

  ////////////////////////////////////////////////////////////////////////
  // millisecond tick
  logic [$clog2(TICK_CYCLES+1)-1:0] div_q;
  logic                            tick;
  assign tick = (div_q == ($bits(div_q))'(TICK_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (srst || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pair decode
  function automatic logic pair_active(input logic [3:0] s);
    pair_active = (s[3] & s[2]) | (s[2] & s[1]) | (s[1] & s[0]);
  endfunction : pair_active

  logic any_pair, all_free, lamp_any, back_pair;
  assign any_pair  = pair_active(sens);
  assign all_free  = (sens == 4'h0);
  assign lamp_any  = lint | lext;
  assign back_pair = b1 & b2;

  logic delayed, immed;
  assign delayed = (end_mode == smc_pkg::SMC_END_DELAYED) || (end_mode == smc_pkg::SMC_END_COMBINED);
  assign immed   = (end_mode == smc_pkg::SMC_END_IMMEDIATE) || (end_mode == smc_pkg::SMC_END_COMBINED);

  ////////////////////////////////////////////////////////////////////////
  // limits in milliseconds
  logic [31:0] limit_ms, delay_ms, dly_cap_s;
  always_comb begin
    if (FIXED_LIMIT || mute_limit_sel == smc_pkg::MUTE_SEL_HOUR) begin
      limit_ms = HOUR_MS;
    end else if (mute_limit_sel < 8'(smc_pkg::MUTE_MAX_MIN_S)) begin
      limit_ms = smc_pkg::MUTE_MAX_MIN_S * smc_pkg::MS_PER_S;
    end else if (mute_limit_sel > 8'(smc_pkg::MUTE_MAX_MAX_S)) begin
      limit_ms = smc_pkg::MUTE_MAX_MAX_S * smc_pkg::MS_PER_S;
    end else begin
      limit_ms = 32'(mute_limit_sel) * smc_pkg::MS_PER_S;
    end
  end
  always_comb begin
    dly_cap_s = immed ? smc_pkg::DELAY_MAX_CMB_S : smc_pkg::DELAY_MAX_S;
    if (32'(end_delay_sel) > dly_cap_s) begin
      delay_ms = dly_cap_s * smc_pkg::MS_PER_S;
    end else begin
      delay_ms = 32'(end_delay_sel) * smc_pkg::MS_PER_S;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // muting state machine
  typedef enum logic [2:0] {
    SMC_RUN, SMC_ARMED, SMC_MUTE, SMC_HOLD, SMC_STOPPED, SMC_OVR
  } smc_state_e;
  smc_state_e st_q;

  logic [31:0] mt_q;
  logic [31:0] dl_q;
  logic [31:0] ov_q;
  logic        resume_q;
  logic        rearm_q;
  logic        broke_q;
  logic        ovr_ok_q;
  logic        waitrel_q;
  logic can_mute, time_out, end_mute;
  assign can_mute = rearm_q & lamp_any & any_pair & (!delayed | back_pair);
  assign time_out = !immed && (mt_q >= limit_ms);
  // a sensor change while muted lifts the pause though time-stop stays applied
  always_ff @(posedge clk) begin
    if (srst || !tstop || st_q != SMC_MUTE) begin
      resume_q <= 1'b0;
    end else if (sens_chg) begin
      resume_q <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst || st_q != SMC_MUTE) begin
      mt_q <= '0;
    end else if (tick && (!tstop || resume_q)) begin
      mt_q <= mt_q + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst || st_q != SMC_HOLD) begin
      dl_q <= '0;
    end else if (tick) begin
      dl_q <= dl_q + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (srst || st_q != SMC_OVR) begin
      ov_q <= '0;
    end else if (tick) begin
      ov_q <= ov_q + 1'b1;
    end
  end

  // any end of muting blocks re-entry until all sensors free
  always_ff @(posedge clk) begin
    if (srst) begin
      rearm_q <= 1'b0;
    end else if (all_free) begin
      rearm_q <= 1'b1;
    end else if (st_q == SMC_MUTE || st_q == SMC_HOLD) begin
      if (end_mute) begin
        rearm_q <= 1'b0;
      end
    end
  end

  // override allowed after expiry or power-up, never in cycle mode
  always_ff @(posedge clk) begin
    if (srst) begin
      ovr_ok_q <= 1'b1;
    end else if (st_q == SMC_MUTE && time_out) begin
      ovr_ok_q <= 1'b1;
    end else if (all_free) begin
      ovr_ok_q <= 1'b0;
    end
  end

  always_comb begin
    end_mute = 1'b0;
    if (!lamp_any) begin
      end_mute = 1'b1;
    end else if (st_q == SMC_MUTE) begin
      end_mute = time_out || (!any_pair && !delayed) || (immed && clr && !clr_q && !broke_q);
    end else if (st_q == SMC_HOLD) begin
      end_mute = (dl_q >= delay_ms) || (immed && clr && !clr_q);
    end
  end

  // a field break since muting last ran blocks the immediate end in the first muted cycle
  always_ff @(posedge clk) begin
    if (srst || st_q == SMC_MUTE) begin
      broke_q <= 1'b0;
    end else if (!clr) begin
      broke_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q      <= SMC_STOPPED;
      waitrel_q <= 1'b0;
    end else begin
      unique case (st_q)
        SMC_RUN: begin
          if (can_mute && (!delayed || !clr)) begin
            st_q <= SMC_MUTE;
          end else if (!clr) begin
            st_q <= SMC_STOPPED;
          end
        end
        SMC_ARMED: begin
          st_q <= SMC_RUN;
        end
        SMC_MUTE: begin
          if (end_mute) begin
            st_q <= clr ? SMC_RUN : SMC_STOPPED;
          end else if (delayed && !any_pair) begin
            st_q <= SMC_HOLD;
          end
        end
        SMC_HOLD: begin
          if (end_mute) begin
            st_q <= clr ? SMC_RUN : SMC_STOPPED;
          end else if (any_pair) begin
            st_q <= SMC_MUTE;
          end
        end
        SMC_STOPPED: begin
          if (btn && !btn_q) begin
            waitrel_q <= 1'b1;
          end
          if (!clr && any_pair && ovr_ok_q && !cycle_mode && btn_rel) begin
            st_q      <= SMC_OVR;
            waitrel_q <= 1'b0;
          end else if (clr && (!restart_interlock || (waitrel_q && btn_rel))) begin
            st_q      <= SMC_ARMED;
            waitrel_q <= 1'b0;
          end else if (!clr && !btn) begin
            waitrel_q <= 1'b0;
          end
        end
        SMC_OVR: begin
          if (clr) begin
            st_q <= SMC_RUN;
          end else if (ov_q >= OVR_WIN_MS) begin
            st_q <= SMC_STOPPED;
          end
        end
        default: st_q <= SMC_STOPPED;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs and lamps
  logic [$clog2(smc_pkg::FLASH_HALF_MS+1)-1:0] fl_cnt_q;
  logic                                         fl_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      fl_cnt_q <= '0;
      fl_q     <= 1'b0;
    end else if (tick) begin
      if (fl_cnt_q == ($bits(fl_cnt_q))'(smc_pkg::FLASH_HALF_MS - 1)) begin
        fl_cnt_q <= '0;
        fl_q     <= ~fl_q;
      end else begin
        fl_cnt_q <= fl_cnt_q + 1'b1;
      end
    end
  end

  logic mute_now, lamp_lvl;
  assign mute_now = (st_q == SMC_MUTE) || (st_q == SMC_HOLD);
  assign lamp_lvl = (lint && lext) ? 1'b1 : fl_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      outputs_on      <= 1'b0;
      muted           <= 1'b0;
      override_active <= 1'b0;
      lamp_int_on     <= 1'b0;
      lamp_ext_on     <= 1'b0;
    end else begin
      outputs_on      <= (st_q == SMC_RUN && clr) || mute_now || st_q == SMC_OVR;
      muted           <= mute_now;
      override_active <= (st_q == SMC_OVR);
      lamp_int_on     <= mute_now & lint & lamp_lvl;
      lamp_ext_on     <= mute_now & lext & lamp_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_ovr_start;
    st_q != SMC_OVR ##1 st_q == SMC_OVR;
  endsequence

  chk_mute_needs_pair: assert property (@(posedge clk) disable iff (srst)
    st_q != SMC_MUTE ##1 st_q == SMC_MUTE |-> $past(any_pair))
    else $error("mute entered without sensor pair");
  chk_mute_needs_lamp: assert property (@(posedge clk) disable iff (srst)
    st_q != SMC_MUTE ##1 st_q == SMC_MUTE |-> $past(lamp_any))
    else $error("mute entered with no lamp");
  chk_mute_rearm: assert property (@(posedge clk) disable iff (srst)
    st_q != SMC_MUTE && st_q != SMC_HOLD ##1 st_q == SMC_MUTE |-> $past(rearm_q))
    else $error("mute re-entered before release");
  chk_limit_ends: assert property (@(posedge clk) disable iff (srst)
    st_q == SMC_MUTE && time_out |=> st_q != SMC_MUTE)
    else $error("mute outlived time limit");
  chk_no_ovr_cycle: assert property (@(posedge clk) disable iff (srst)
    st_q == SMC_STOPPED && cycle_mode |=> st_q != SMC_OVR)
    else $error("override in cycle mode");
  chk_ovr_window: assert property (@(posedge clk) disable iff (srst)
    st_q == SMC_OVR && ov_q >= OVR_WIN_MS && !clr |=> st_q == SMC_STOPPED)
    else $error("override outlived window");
  chk_field_off: assert property (@(posedge clk) disable iff (srst)
    st_q == SMC_STOPPED |=> !outputs_on)
    else $error("outputs on while stopped");
  chk_lamp_steady: assert property (@(posedge clk) disable iff (srst)
    mute_now && lint && lext |=> lamp_int_on && lamp_ext_on)
    else $error("lamps not steady with both ok");
  chk_ovr_begin: assert property (@(posedge clk) disable iff (srst)
    s_ovr_start |-> $past(st_q) == SMC_STOPPED && $past(ovr_ok_q))
    else $error("override without cause");

endmodule : smc_muting_controller

`default_nettype wire

/* smc_partner.sv */
`timescale 1ns/10ps
`default_nettype none

module smc_partner (
  input  wire logic       clk,
  input  wire logic [3:0] sens_req,
  input  wire logic       field_req,
  input  wire logic       press_req,
  input  wire logic [3:0] hold_len,
  output logic            sensor_front_one,
  output logic            sensor_front_two,
  output logic            sensor_back_one,
  output logic            sensor_back_two,
  output logic            field_clear,
  output logic            start_button
);
  int press_cnt = 0;

  // conducting level only while material is seen
  assign {sensor_back_two, sensor_back_one, sensor_front_two, sensor_front_one} = sens_req;
  assign field_clear = field_req;

  // operator holds the button a variable time, then lets go
  always_ff @(posedge clk) begin
    if (press_req && press_cnt == 0) begin
      press_cnt <= int'(hold_len) + 3;
    end else if (press_cnt > 0) begin
      press_cnt <= press_cnt - 1;
    end
  end
  assign start_button = (press_cnt > 2);
endmodule : smc_partner

`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED t=%0t %s", $time, msg); end end

module tb_top;
  logic              clk = 1'b0;
  logic              srst = 1'b1;
  logic [3:0]        sens = 4'h0;
  logic              field = 1'b1;
  logic              press = 1'b0;
  logic [3:0]        hold = 4'h0;
  logic              tstop = 1'b0;
  logic              lint = 1'b1;
  logic              lext = 1'b1;
  logic              rilk = 1'b0;
  logic              cyc = 1'b0;
  smc_pkg::smc_end_e mode = smc_pkg::SMC_END_NORMAL;
  logic [7:0]        lim = 8'h01;
  logic [7:0]        dly = 8'h00;
  wire logic         f1, f2, b1, b2, fc, sb;
  logic              oon, mut, ovr, li, le;
  int                failures = 0;
  int                samples_checked = 0;
  int                k, s, h;
  logic [3:0]        s_tab [4] = '{4'h3, 4'h7, 4'h6, 4'hC};

  initial begin
    forever #4 clk = ~clk;
  end

  smc_partner part_u (.clk(clk), .sens_req(sens), .field_req(field), .press_req(press), .hold_len(hold),
    .sensor_front_one(f1), .sensor_front_two(f2), .sensor_back_one(b1), .sensor_back_two(b2),
    .field_clear(fc), .start_button(sb));

  // short tick: 1 s is 10000 cycles, override window 200 cycles
  smc_muting_controller #(.TICK_CYCLES(10), .OVR_WIN_MS(20), .HOUR_MS(50), .FIXED_LIMIT(1'b0)) dut_u (
    .clk(clk), .srst(srst), .sensor_front_one(f1), .sensor_front_two(f2), .sensor_back_one(b1),
    .sensor_back_two(b2), .field_clear(fc), .time_stop_input(tstop), .start_button(sb),
    .lamp_int_ok(lint), .lamp_ext_ok(lext), .restart_interlock(rilk), .cycle_mode(cyc),
    .end_mode(mode), .mute_limit_sel(lim), .end_delay_sel(dly), .outputs_on(oon), .muted(mut),
    .override_active(ovr), .lamp_int_on(li), .lamp_ext_on(le));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic pair_ok(input int v);
    return ((v & 3) == 3) || ((v & 6) == 6) || ((v & 12) == 12);
  endfunction : pair_ok

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc_n

  task automatic wait_sig(input bit on_out, input logic v, input int bound);
    int i;
    for (i = 0; i < bound && (on_out ? oon : mut) !== v; i++) cyc_n(1);
    `CHK(on_out ? oon : mut, v, "bounded wait")
    if ((on_out ? oon : mut) !== v) begin
      end_of_test();
    end
  endtask : wait_sig

  task automatic push_start;
    hold = 4'($urandom_range(9, 0));
    press = 1'b1;
    cyc_n(1);
    press = 1'b0;
  endtask : push_start

  task automatic end_of_test;
    $display("samples_checked=%0d failures=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(13300));
    cyc_n(3);
    srst = 1'b0;
    `CHK(oon, 1'b0, "off after reset")
    wait_sig(1, 1'b1, 20);
    field = 1'b0;
    wait_sig(1, 1'b0, 10);
    field = 1'b1;
    wait_sig(1, 1'b1, 10);
    // the three pairs first, then random patterns
    for (k = 0; k < 14; k++) begin
      s = (k < 3) ? (3 << k) : $urandom_range(15, 1);
      sens = s[3:0];
      cyc_n(10);
      `CHK(mut, pair_ok(s), "pair muting")
      sens = 4'h0;
      cyc_n(10);
    end
    foreach (s_tab[j]) begin
      sens = s_tab[j];
      cyc_n(8);
    end
    `CHK(mut, 1'b1, "handover")
    field = 1'b0;
    cyc_n(8);
    `CHK(oon, 1'b1, "muted field break")
    `CHK(li & le, 1'b1, "steady lamps")
    lext = 1'b0;
    h = 0;
    for (k = 0; k < 5000; k++) begin
      cyc_n(1);
      h += int'(li);
    end
    `CHK(h > 1000 && h < 4000, 1'b1, "lamp flashes")
    field = 1'b1;
    sens = 4'h0;
    lint = 1'b0;
    cyc_n(10);
    sens = 4'h3;
    cyc_n(10);
    `CHK(mut, 1'b0, "no lamp no muting")
    sens = 4'h0;
    lint = 1'b1;
    lext = 1'b1;
    cyc_n(10);
    // limit of 1 s, then override after expiry
    sens = 4'h3;
    wait_sig(0, 1'b1, 10);
    cyc_n(9900);
    `CHK(mut, 1'b1, "before limit")
    wait_sig(0, 1'b0, 200);
    field = 1'b0;
    wait_sig(1, 1'b0, 10);
    cyc = 1'b1;
    push_start();
    cyc_n(30);
    `CHK(oon, 1'b0, "no override in cycle mode")
    cyc = 1'b0;
    push_start();
    wait_sig(1, 1'b1, 30);
    `CHK(ovr, 1'b1, "override on")
    cyc_n(170);
    `CHK(oon, 1'b1, "inside window")
    wait_sig(1, 1'b0, 60);
    field = 1'b1;
    cyc_n(10);
    `CHK(mut, 1'b0, "no re-mute held")
    sens = 4'h0;
    cyc_n(10);
    sens = 4'h3;
    wait_sig(0, 1'b1, 10);
    tstop = 1'b1;
    cyc_n(10400);
    `CHK(mut, 1'b1, "paused timer")
    sens = 4'h7;
    wait_sig(0, 1'b0, 10300);
    tstop = 1'b0;
    sens = 4'h0;
    rilk = 1'b1;
    field = 1'b0;
    wait_sig(1, 1'b0, 10);
    field = 1'b1;
    cyc_n(10);
    `CHK(oon, 1'b0, "waits for start")
    push_start();
    wait_sig(1, 1'b1, 30);
    mode = smc_pkg::SMC_END_IMMEDIATE;
    sens = 4'h3;
    wait_sig(0, 1'b1, 10);
    cyc_n(10400);
    `CHK(mut, 1'b1, "no limit with immediate end")
    field = 1'b0;
    cyc_n(8);
    field = 1'b1;
    wait_sig(0, 1'b0, 10);
    sens = 4'h0;
    mode = smc_pkg::SMC_END_DELAYED;
    cyc_n(10);
    sens = 4'hC;
    cyc_n(10);
    `CHK(mut, 1'b0, "back pair without break")
    sens = 4'h0;
    cyc_n(10);
    // field broken as the back pair is reached
    field = 1'b0;
    sens = 4'hC;
    wait_sig(0, 1'b1, 10);
    dly = 8'h01;
    field = 1'b1;
    cyc_n(10);
    sens = 4'h0;
    cyc_n(9000);
    `CHK(mut, 1'b1, "end delay holds")
    wait_sig(0, 1'b0, 1200);
    mode = smc_pkg::SMC_END_COMBINED;
    field = 1'b0;
    sens = 4'hC;
    wait_sig(0, 1'b1, 10);
    sens = 4'h0;
    cyc_n(10);
    `CHK(mut, 1'b1, "combined delay running")
    field = 1'b1;
    wait_sig(0, 1'b0, 10);
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
